// ---- logic/voice_pkg.sv ----
// Register map, field positions and timing constants of the voice channel
package voice_pkg;
   // Register byte addresses
   localparam logic [7:0] A_CTRL  = 8'h00;
   localparam logic [7:0] A_STAT  = 8'h04;
   localparam logic [7:0] A_SEG   = 8'h08;
   localparam logic [7:0] A_BYTE  = 8'h0C;
   localparam logic [7:0] A_WAVE  = 8'h10;
   localparam logic [7:0] A_PITL  = 8'h14;
   localparam logic [7:0] A_PITH  = 8'h18;
   localparam logic [7:0] A_OCT   = 8'h1C;
   localparam logic [7:0] A_VOL   = 8'h20;
   localparam logic [7:0] A_RAMP  = 8'h24;
   localparam logic [7:0] A_TCTL  = 8'h30;
   localparam logic [7:0] A_TSTAT = 8'h3C;
   localparam logic [7:0] A_TBASE = 8'h40;

   // Channel control bits
   localparam int C_LOAD = 0;
   localparam int C_RUN  = 1;
   localparam int C_DOWN = 2;
   localparam int C_FUP  = 3;
   localparam int C_FDN  = 4;
   localparam int C_PSEG = 5;
   localparam int C_RAMP = 6;
   localparam logic [6:0] CTRL_RST = 7'h00;

   // Channel status bits
   localparam int S_END  = 0;
   localparam int S_ZC   = 1;
   localparam int S_TERM = 2;
   localparam int S_ZCI  = 3;

   // Timer control bits
   localparam int T_HOLD = 0;
   localparam int T_EXT  = 1;
   localparam int T_OE   = 7;
   localparam logic [7:0] TCTL_RST = 8'h01;
   localparam int SEG_TMR = 2;

   // Address counter landmarks
   localparam logic [6:0] SEG_LAST  = 7'h7F;
   localparam logic [6:0] BYTE_LAST = 7'h7F;
   localparam logic [6:0] BYTE_MID  = 7'h3F;

   // Internal timer tick
   localparam int PCLK_MHZ = 20;
   localparam int TICK_NS  = 1000;
   localparam int INT_DIV  = TICK_NS * PCLK_MHZ / 1000;
endpackage : voice_pkg

// ---- logic/voice_channel_control.sv ----
// Voice channel control: address, envelope, pitch, volume and timers
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/100ps
module voice_channel_control
   import voice_pkg::*;
#(
   parameter int N_TMR   = 3,       // Number of timers
   parameter int TICK_DV = INT_DIV  // Clocks per internal timer tick
) (
   input  wire logic             pclk,              // APB clock
   input  wire logic             presetn,           // Async reset, active low
   input  wire logic             psel,              // APB select
   input  wire logic             penable,           // APB enable
   input  wire logic             pwrite,            // APB direction
   input  wire logic [7:0]       paddr,             // APB byte address
   input  wire logic [31:0]      pwdata,            // APB write data
   output logic      [31:0]      prdata,            // APB read data
   output logic                  pready,            // APB ready
   output logic                  pslverr,           // APB error, unmapped
   input  wire logic [N_TMR-1:0] ext_clk,           // External timer clocks
   output logic      [N_TMR-1:0] timer_out,         // Timer outputs
   output logic                  waveform_end_flag, // Waveform_end_flag flag
   output logic      [7:0]       sample_out,        // Waveform byte
   output logic      [7:0]       envelope_level,    // Ramp level
   output logic      [7:0]       volume_level       // Latched volume
);

   if (N_TMR < 1 || N_TMR > 3 || TICK_DV < 1 || TICK_DV > 65536) begin : g_bad_params
      $error("voice_channel_control: bad parameters");
   end

   // Timer data decode: {hit, high byte, index}
   function automatic logic [3:0] tdec(input logic [7:0] a);
      logic hit;
      hit = (a[7:5] == A_TBASE[7:5]) && (int'(a[4:3]) < N_TMR) && (a[1:0] == 2'b00);
      return {hit, ~a[2], a[4:3]};
   endfunction : tdec

   // Timer control decode: {hit, index}
   function automatic logic [2:0] cdec(input logic [7:0] a);
      logic hit;
      hit = (a[7:4] == A_TCTL[7:4]) && (int'(a[3:2]) < N_TMR) && (a[1:0] == 2'b00);
      return {hit, a[3:2]};
   endfunction : cdec

   logic [7:0]  mem [0:16383];
   logic [6:0]  ctrl_r;
   logic [6:0]  seg_r;
   logic [6:0]  byte_r;
   logic [9:0]  pitch_r;
   logic [2:0]  octave_r;
   logic [7:0]  volume_r;
   logic [7:0]  ramp_r;
   logic [7:0]  preset_r;
   logic [17:0] phase_r;
   logic        end_r;
   logic        zci_r;
   logic        armed_r;
   logic        pready_r;
   logic        perr_r;
   logic [31:0] prdata_r;
   logic [7:0]  sample_r;
   logic [15:0] tcnt_r   [N_TMR];
   logic [15:0] tlatch_r [N_TMR];
   logic [7:0]  tctl_r   [N_TMR];
   logic [7:0]  tmsb_r   [N_TMR];
   logic [7:0]  tsnap_r  [N_TMR];
   logic [N_TMR-1:0] tstat_r;
   logic [N_TMR-1:0] tout_r;
   logic [N_TMR-1:0] ext_s1_r;
   logic [N_TMR-1:0] ext_s2_r;
   logic [N_TMR-1:0] ext_s3_r;
   logic [15:0] div_r;

   logic        acc;
   logic        wr;
   logic        rd;
   logic [3:0]  td;
   logic [2:0]  cd;
   logic        run_adv;
   logic        adv;
   logic        seg_wr;
   logic        byte_wr;
   logic        end_ev;
   logic        zc_ev;
   logic        term;
   logic        step;
   logic        up;
   logic        down;
   logic        pre_ld;
   logic        int_tick;
   logic [18:0] phase_nxt;
   logic [17:0] inc;
   logic [N_TMR-1:0] tick;
   logic [N_TMR-1:0] tto;
   logic [7:0]  rd_nxt;
   logic        err_nxt;

   // APB: one wait state, effects only at the completing edge
   assign acc     = psel && penable && pready_r;
   assign wr      = acc && pwrite;
   assign rd      = acc && !pwrite;
   assign td      = tdec(paddr);
   assign cd      = cdec(paddr);
   assign seg_wr  = wr && (paddr == A_SEG);
   assign byte_wr = wr && (paddr == A_BYTE);

   // Address rate is pitch shifted by octave
   assign inc       = 18'({8'h00, pitch_r}) << octave_r;
   assign phase_nxt = {1'b0, phase_r} + {1'b0, inc};
   assign run_adv   = ctrl_r[C_RUN] && phase_nxt[18];
   assign adv       = run_adv || (acc && paddr == A_WAVE
                      && ctrl_r[C_LOAD] && !ctrl_r[C_RUN]);
   assign end_ev    = adv && !seg_wr && !byte_wr
                      && seg_r == SEG_LAST && byte_r == BYTE_LAST;
   assign zc_ev     = adv && !seg_wr && !byte_wr && byte_r == BYTE_MID;

   // Envelope direction, forces override the direction bit
   assign up     = ctrl_r[C_FUP] || (!ctrl_r[C_FDN] && !ctrl_r[C_DOWN]);
   assign down   = ctrl_r[C_FDN] || (!ctrl_r[C_FUP] && ctrl_r[C_DOWN]);
   assign step   = adv && ctrl_r[C_RAMP];
   assign pre_ld = adv && byte_r == BYTE_LAST && ctrl_r[C_PSEG];
   assign term   = (ramp_r == 8'h00) || (ramp_r == 8'hFF);

   assign int_tick = (div_r == 16'(TICK_DV - 1));

   always_comb begin
      for (int i = 0; i < N_TMR; i++) begin
         tick[i] = tctl_r[i][T_EXT] ? (ext_s2_r[i] && !ext_s3_r[i]) : int_tick;
         tto[i]  = !tctl_r[i][T_HOLD] && tick[i] && tcnt_r[i] == 16'h0001;
      end
   end

   // Read data mux
   always_comb begin
      rd_nxt  = 8'h00;
      err_nxt = 1'b0;
      if (td[3]) begin
         rd_nxt = td[2] ? tcnt_r[td[1:0]][15:8] : tsnap_r[td[1:0]];
      end else if (cd[2]) begin
         rd_nxt = tctl_r[cd[1:0]];
      end else begin
         unique case (paddr)
            A_CTRL:  rd_nxt = {1'b0, ctrl_r};
            A_STAT:  rd_nxt = {4'h0, zci_r, term, byte_r[6], end_r};
            A_SEG:   rd_nxt = {1'b0, seg_r};
            A_BYTE:  rd_nxt = {1'b0, byte_r};
            A_WAVE:  rd_nxt = sample_r;
            A_PITL:  rd_nxt = pitch_r[7:0];
            A_PITH:  rd_nxt = {6'h00, pitch_r[9:8]};
            A_OCT:   rd_nxt = {5'h00, octave_r};
            A_VOL:   rd_nxt = volume_r;
            A_RAMP:  rd_nxt = ramp_r;
            A_TSTAT: rd_nxt = 8'(tstat_r);
            default: err_nxt = 1'b1;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         perr_r   <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end else begin
         pready_r <= psel && penable && !pready_r;
         if (psel && penable && !pready_r) begin
            perr_r   <= err_nxt;
            prdata_r <= {24'h00_0000, rd_nxt};
         end
      end
   end

   // Control, pitch, octave and volume registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r   <= CTRL_RST;
         pitch_r  <= 10'h000;
         octave_r <= 3'h0;
         volume_r <= 8'h00;
      end else if (wr) begin
         if (paddr == A_CTRL) ctrl_r <= pwdata[6:0];
         if (paddr == A_PITL) pitch_r[7:0] <= pwdata[7:0];
         if (paddr == A_PITH) pitch_r[9:8] <= pwdata[1:0];
         if (paddr == A_OCT) octave_r <= pwdata[2:0];
         if (paddr == A_VOL) volume_r <= pwdata[7:0];
      end
   end

   // Phase accumulator and waveform address counters
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_r <= 18'h0_0000;
         seg_r   <= 7'h00;
         byte_r  <= 7'h00;
      end else begin
         phase_r <= ctrl_r[C_RUN] ? phase_nxt[17:0] : 18'h0_0000;
         if (seg_wr) begin
            seg_r  <= pwdata[6:0];
            byte_r <= 7'h00;
         end else if (byte_wr) begin
            byte_r <= 7'h00;
         end else if (adv) begin
            byte_r <= byte_r + 7'h01;
            if (byte_r == BYTE_LAST) seg_r <= seg_r + 7'h01;
         end
      end
   end

   // Waveform memory
   always_ff @(posedge pclk) begin
      if (wr && paddr == A_WAVE) mem[{seg_r, byte_r}] <= pwdata[7:0];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) sample_r <= 8'h00;
      else sample_r <= mem[{seg_r, byte_r}];
   end

   // Channel flags, set wins over a write-one clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         end_r   <= 1'b0;
         zci_r   <= 1'b0;
         armed_r <= 1'b0;
      end else begin
         if (end_ev) end_r <= 1'b1;
         else if (wr && paddr == A_STAT && pwdata[S_END]) end_r <= 1'b0;
         if (armed_r && zc_ev) zci_r <= 1'b1;
         else if (wr && paddr == A_STAT && pwdata[S_ZCI]) zci_r <= 1'b0;
         if (tto[SEG_TMR % N_TMR]) armed_r <= 1'b1;
         else if (zc_ev) armed_r <= 1'b0;
      end
   end

   // Envelope ramp counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ramp_r   <= 8'h00;
         preset_r <= 8'h00;
      end else if (wr && paddr == A_RAMP) begin
         ramp_r   <= pwdata[7:0];
         preset_r <= pwdata[7:0];
      end else if (pre_ld) begin
         ramp_r <= preset_r;
      end else if (step) begin
         if (up && !down && ramp_r != 8'hFF) ramp_r <= ramp_r + 8'h01;
         if (down && !up && ramp_r != 8'h00) ramp_r <= ramp_r - 8'h01;
      end
   end

   // External clock synchronisers and internal tick divider
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_s1_r <= '0;
         ext_s2_r <= '0;
         ext_s3_r <= '0;
         div_r    <= 16'h0000;
      end else begin
         ext_s1_r <= ext_clk;
         ext_s2_r <= ext_s1_r;
         ext_s3_r <= ext_s2_r;
         div_r    <= int_tick ? 16'h0000 : div_r + 16'h0001;
      end
   end

   // Timers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < N_TMR; i++) begin
            tcnt_r[i]   <= 16'h0000;
            tlatch_r[i] <= 16'h0000;
            tctl_r[i]   <= TCTL_RST;
            tmsb_r[i]   <= 8'h00;
            tsnap_r[i]  <= 8'h00;
         end
         tstat_r <= '0;
         tout_r  <= '0;
      end else begin
         for (int i = 0; i < N_TMR; i++) begin
            if (wr && cd[2] && int'(cd[1:0]) == i) tctl_r[i] <= pwdata[7:0];
            if (wr && td[3] && td[2] && int'(td[1:0]) == i) begin
               tmsb_r[i] <= pwdata[7:0];
            end
            if (wr && td[3] && !td[2] && int'(td[1:0]) == i) begin
               tlatch_r[i] <= {tmsb_r[i], pwdata[7:0]};
            end
            if (rd && td[3] && td[2] && int'(td[1:0]) == i) begin
               tsnap_r[i] <= tcnt_r[i][7:0];
            end
            if (tctl_r[i][T_HOLD]) begin
               tcnt_r[i] <= tlatch_r[i];
            end else if (tto[i]) begin
               tcnt_r[i] <= tlatch_r[i];
            end else if (tick[i]) begin
               tcnt_r[i] <= tcnt_r[i] - 16'h0001;
            end
            if (tto[i]) begin
               tstat_r[i] <= 1'b1;
               if (tctl_r[i][T_OE]) tout_r[i] <= !tout_r[i];
            end else if (wr && paddr == A_TSTAT && pwdata[i]) begin
               tstat_r[i] <= 1'b0;
            end
         end
      end
   end

   assign prdata            = prdata_r;
   assign pready            = pready_r;
   assign pslverr           = perr_r;
   assign timer_out         = tout_r;
   assign waveform_end_flag = end_r;
   assign sample_out        = sample_r;
   assign envelope_level    = ramp_r;
   assign volume_level      = volume_r;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_ramp_up;
      step && up && !down && !pre_ld && !(wr && paddr == A_RAMP) && ramp_r != 8'hFF
         |=> ramp_r == $past(ramp_r) + 8'h01;
   endproperty
   a_ramp_up: assert property (p_ramp_up) else $error("ramp did not count up");

   property p_force_dn;
      step && ctrl_r[C_FDN] && !ctrl_r[C_FUP] && !pre_ld && !(wr && paddr == A_RAMP)
         && ramp_r != 8'h00 |=> ramp_r == $past(ramp_r) - 8'h01;
   endproperty
   a_force_dn: assert property (p_force_dn) else $error("force down ignored");

   property p_preset;
      wr && paddr == A_RAMP |=> ramp_r == $past(pwdata[7:0])
         && term == ($past(pwdata[7:0]) == 8'h00 || $past(pwdata[7:0]) == 8'hFF);
   endproperty
   a_preset: assert property (p_preset) else $error("ramp preset not loaded");

   property p_hold;
      tctl_r[0][T_HOLD] && $past(tctl_r[0][T_HOLD]) && $stable(tlatch_r[0])
         |-> tcnt_r[0] == tlatch_r[0];
   endproperty
   a_hold: assert property (p_hold) else $error("held timer differs from latch");

   property p_latch;
      wr && td[3] && !td[2] && td[1:0] == 2'b00
         |=> tlatch_r[0] == {$past(tmsb_r[0]), $past(pwdata[7:0])};
   endproperty
   a_latch: assert property (p_latch) else $error("two-byte latch write wrong");

   property p_tmo;
      tto[0] |=> tstat_r[0] && tcnt_r[0] == $past(tlatch_r[0]);
   endproperty
   a_tmo: assert property (p_tmo) else $error("timeout not flagged");

   property p_end;
      $rose(end_r) |-> $past(seg_r) == SEG_LAST && $past(byte_r) == BYTE_LAST;
   endproperty
   a_end: assert property (p_end) else $error("end flag at wrong address");

   property p_zc;
      zc_ev |=> byte_r == 7'h40 && !$past(byte_r[6]);
   endproperty
   a_zc: assert property (p_zc) else $error("zero cross count wrong");

   property p_zci;
      $rose(zci_r) |-> $past(armed_r) && $past(zc_ev);
   endproperty
   a_zci: assert property (p_zci) else $error("zero cross irq without timeout");

   property p_apb;
      psel && penable && !pready_r |=> pready_r ##1 !pready_r;
   endproperty
   a_apb: assert property (p_apb) else $error("apb ready timing wrong");

   c_end: cover property (end_ev);
   c_zci: cover property ($rose(zci_r));
   c_tmo: cover property (tto[0] && tctl_r[0][T_EXT]);
   c_pre: cover property (pre_ld && step);
endmodule : voice_channel_control

// ---- testbench/host_bus_model.sv ----
// APB host model that drives the voice channel register bus
`timescale 1ns/100ps
module host_bus_model (
   input  wire logic        pclk,    // Bus clock
   output logic             psel,    // Select
   output logic             penable, // Enable
   output logic             pwrite,  // Direction
   output logic [7:0]       paddr,   // Byte address
   output logic [31:0]      pwdata,  // Write data
   input  wire logic [31:0] prdata,  // Read data
   input  wire logic        pready,  // Ready
   input  wire logic        pslverr  // Error response
);
   logic bus_err;

   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0000_0000;
      bus_err = 1'b0;
   end

   // One byte transfer; the request stands until pready is sampled high
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= {24'h00_0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata[7:0];
      bus_err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : xfer

   // Sixteen-bit values travel as high byte then low byte
   task automatic wr16(input logic [7:0] a, input logic [15:0] v);
      logic [7:0] q;
      xfer(1'b1, a, v[15:8], q);
      xfer(1'b1, a + 8'h04, v[7:0], q);
   endtask : wr16

   task automatic rd16(input logic [7:0] a, output logic [15:0] v);
      xfer(1'b0, a, 8'h00, v[15:8]);
      xfer(1'b0, a + 8'h04, 8'h00, v[7:0]);
   endtask : rd16
endmodule : host_bus_model

// ---- testbench/testbench.sv ----
// Self-checking bench for the voice channel control block
`timescale 1ns/100ps
module testbench;
   import voice_pkg::*;
   localparam int TICK = 20;
   logic        pclk;
   logic        presetn;
   logic [2:0]  ext_clk;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [2:0]  timer_out;
   logic        waveform_end_flag;
   logic [7:0]  sample_out;
   logic [7:0]  envelope_level;
   logic [7:0]  volume_level;
   int          fails = 0;
   int          num_checks = 0;
   int          cycles = 0;

   host_bus_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   voice_channel_control #(.N_TMR(3), .TICK_DV(TICK)) dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_clk(ext_clk),
      .timer_out(timer_out), .waveform_end_flag(waveform_end_flag), .sample_out(sample_out),
      .envelope_level(envelope_level), .volume_level(volume_level));

   initial pclk = 1'b0;
   always #25 pclk = ~pclk;

   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         fails++;
         end_of_test();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      host.xfer(1'b1, a, d, q);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      host.xfer(1'b0, a, 8'h00, q);
   endtask : rd

   // Waveform accesses in load mode, then let the ramp settle
   task automatic adv(input int n);
      repeat (n) wr(A_WAVE, 8'h00);
      repeat (2) @(negedge pclk);
   endtask : adv

   task automatic hold_all;
      logic [7:0] q;
      for (int t = 0; t < 3; t++) wr(A_TCTL + 8'(4 * t), 8'h81);
      wr(A_TSTAT, 8'h07);
      rd(A_TSTAT, q);
      check(q, 8'h00);
   endtask : hold_all

   task automatic pulse_ext;
      @(posedge pclk);
      ext_clk <= 3'b111;
      repeat (4) @(posedge pclk);
      ext_clk <= 3'b000;
      repeat (6) @(posedge pclk);
   endtask : pulse_ext

   task automatic t_regs;
      logic [7:0] q;
      logic [7:0] vv [3] = '{8'hFF, 8'h00, 8'h5A};
      // Ramp resets to zero, so only the terminal flag is up
      rd(A_STAT, q);
      check(q, 8'h04);
      for (int i = 0; i < 3; i++) begin
         wr(A_VOL, vv[i]);
         @(negedge pclk);
         check(volume_level, vv[i]);
      end
      rd(8'hFC, q);
      check({host.bus_err, q}, 9'h100);
      $display("test registers done");
   endtask : t_regs

   task automatic t_ramp;
      logic [7:0] q;
      logic [7:0] ctl [4] = '{8'h04, 8'h04, 8'h00, 8'h00};
      logic [7:0] pre [4] = '{8'hAA, 8'h00, 8'h7F, 8'hFF};
      for (int i = 0; i < 4; i++) begin
         wr(A_CTRL, ctl[i]);
         wr(A_RAMP, pre[i]);
         rd(A_STAT, q);
         check(q[S_TERM], i % 2);
         @(negedge pclk);
         check(envelope_level, pre[i]);
      end
      wr(A_CTRL, 8'h41);
      wr(A_RAMP, 8'h05);
      adv(3);
      check(envelope_level, 8'h08);
      wr(A_CTRL, 8'h51);
      adv(3);
      check(envelope_level, 8'h05);
      wr(A_CTRL, 8'h4D);
      adv(3);
      check(envelope_level, 8'h08);
      wr(A_CTRL, 8'h45);
      wr(A_RAMP, 8'h01);
      adv(3);
      check(envelope_level, 8'h00);
      rd(A_STAT, q);
      check(q[S_TERM], 1'b1);
      $display("test ramp done");
   endtask : t_ramp

   task automatic t_wave;
      logic [7:0] q;
      wr(A_CTRL, 8'h61);
      wr(A_RAMP, 8'h10);
      wr(A_SEG, {1'b0, SEG_LAST});
      for (int k = 1; k <= 128; k++) begin
         wr(A_WAVE, 8'(k));
         @(negedge pclk);
         if (k < 128) check(waveform_end_flag, 1'b0);
         if (k == 5) begin
            rd(A_BYTE, q);
            check(q, 8'h05);
         end
         if (k == 63 || k == 64) begin
            rd(A_STAT, q);
            check(q[S_ZC], k == 64);
            check(q[S_ZCI], 1'b0);
         end
      end
      repeat (2) @(negedge pclk);
      check(waveform_end_flag, 1'b1);
      check(envelope_level === 8'h10 || envelope_level === 8'h11, 1'b1);
      rd(A_STAT, q);
      check(q[S_END], 1'b1);
      wr(A_STAT, 8'h01);
      rd(A_STAT, q);
      check(q[S_END], 1'b0);
      wr(A_SEG, {1'b0, SEG_LAST});
      repeat (2) @(negedge pclk);
      check(sample_out, 8'h01);
      rd(A_WAVE, q);
      check(q, 8'h01);
      rd(A_WAVE, q);
      check(q, 8'h02);
      $display("test waveform done");
   endtask : t_wave

   task automatic t_rate;
      logic [7:0] q;
      longint     lo;
      longint     hi;
      wr(A_CTRL, 8'h00);
      wr(A_PITL, 8'hFF);
      wr(A_PITH, 8'h03);
      rd(A_PITH, q);
      check(q, 8'h03);
      rd(A_PITL, q);
      check(q, 8'hFF);
      for (int oct = 7; oct > 5; oct--) begin
         wr(A_OCT, 8'(oct));
         rd(A_OCT, q);
         check(q, 8'(oct));
         wr(A_SEG, 8'h00);
         wr(A_CTRL, 8'h02);
         repeat (200) @(posedge pclk);
         wr(A_CTRL, 8'h00);
         rd(A_BYTE, q);
         lo = (longint'(200) * (longint'(10'h3FF) << oct)) >> 18;
         hi = ((longint'(208) * (longint'(10'h3FF) << oct)) >> 18) + 1;
         check(q >= lo && q <= hi, 1'b1);
      end
      $display("test rate done");
   endtask : t_rate

   task automatic t_timers;
      logic [15:0] v;
      logic [7:0]  q;
      int          n;
      hold_all();
      for (int i = 0; i < 3; i++) begin
         for (int t = 0; t < 3; t++) begin
            v = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : 16'h1234;
            host.wr16(A_TBASE + 8'(8 * t), v ^ 16'(16'h0101 * t));
         end
         for (int t = 0; t < 3; t++) begin
            host.rd16(A_TBASE + 8'(8 * t), v);
            check(v ^ 16'(16'h0101 * t), (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : 16'h1234);
         end
      end
      for (int t = 0; t < 3; t++) host.wr16(A_TBASE + 8'(8 * t), 16'h0004);
      for (int t = 0; t < 3; t++) wr(A_TCTL + 8'(4 * t), 8'h80);
      rd(A_TSTAT, q);
      check(q, 8'h00);
      n = 0;
      do begin
         rd(A_TSTAT, q);
         n++;
      end while (q[2:0] != 3'b111 && n < 60);
      check(q, 8'h07);
      @(negedge pclk);
      check(timer_out, 3'b111);
      hold_all();
      for (int t = 0; t < 3; t++) host.wr16(A_TBASE + 8'(8 * t), 16'h0003);
      for (int t = 0; t < 3; t++) wr(A_TCTL + 8'(4 * t), 8'h82);
      pulse_ext();
      pulse_ext();
      rd(A_TSTAT, q);
      check(q, 8'h00);
      pulse_ext();
      rd(A_TSTAT, q);
      check(q, 8'h07);
      @(negedge pclk);
      check(timer_out, 3'b000);
      hold_all();
      $display("test timers done");
   endtask : t_timers

   task automatic t_zci;
      logic [7:0] q;
      wr(A_CTRL, 8'h01);
      wr(A_SEG, 8'h00);
      adv(63);
      rd(A_STAT, q);
      check(q[S_ZCI], 1'b0);
      adv(1);
      rd(A_STAT, q);
      check(q[S_ZCI], 1'b1);
      wr(A_STAT, 8'h08);
      rd(A_STAT, q);
      check(q[S_ZCI], 1'b0);
      $display("test zero cross done");
   endtask : t_zci

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : end_of_test

   initial begin
      presetn = 1'b0;
      ext_clk = 3'b000;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_ramp();
      t_wave();
      t_rate();
      t_timers();
      t_zci();
      end_of_test();
   end
endmodule : testbench
